// File: pkg/spi_port_pkg.sv
package spi_port_pkg;

	// ----------------------------------------
	// register indices (byte address = 4 x index)
	// ----------------------------------------
	localparam int          AXI_AW    = 12;
	localparam logic [9:0]  IDX_STAT  = 10'h0220;
	localparam logic [9:0]  IDX_CON   = 10'h0222;
	localparam logic [9:0]  IDX_BUF   = 10'h0224;
	localparam logic [9:0]  IDX_IRQ   = 10'h0226;
	localparam logic [15:0] RST_STAT  = 16'h0000;
	localparam logic [15:0] RST_CON   = 16'h0000;
	localparam logic [15:0] RST_BUF   = 16'h0000;
	localparam logic [15:0] CON_MASK  = 16'h6fff;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLV  = 2'h2;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int ST_EN    = 15;
	localparam int ST_SIDL  = 13;
	localparam int ST_OVF   = 6;
	localparam int ST_TBF   = 1;
	localparam int ST_RBF   = 0;
	localparam int CN_FRM   = 14;
	localparam int CN_FSD   = 13;
	localparam int CN_DIS   = 11;
	localparam int CN_M16   = 10;
	localparam int CN_SMP   = 9;
	localparam int CN_CKE   = 8;
	localparam int CN_SELECT_CONTROL_ENABLE  = 7;
	localparam int CN_CKP   = 6;
	localparam int CN_MST   = 5;
	localparam int CN_SPRE  = 2;
	localparam int CN_PPRE  = 0;
	localparam int IQ_FLAG  = 0;
	localparam int IQ_EN    = 1;
	localparam int MSB8     = 7;
	localparam int MSB16    = 15;

	// ----------------------------------------
	// word sizes and prescale factors
	// ----------------------------------------
	localparam logic [4:0]  BITS8    = 5'h08;
	localparam logic [4:0]  BITS16   = 5'h10;
	localparam logic [4:0]  CNT_ONE  = 5'h01;
	localparam logic [6:0]  PRI_1    = 7'h01;
	localparam logic [6:0]  PRI_4    = 7'h04;
	localparam logic [6:0]  PRI_16   = 7'h10;
	localparam logic [6:0]  PRI_64   = 7'h40;
	localparam logic [3:0]  SEC_BASE = 4'h8;
	localparam logic [10:0] LIM_ONE  = 11'h001;
	localparam logic [8:0]  DIV_ZERO = 9'h000;
	localparam logic [8:0]  DIV_ONE  = 9'h001;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FRAME = 3'b010,
		ST_SHIFT = 3'b100
	} master_state_e;

	// system clock cycles per half shift clock period, minus one
	function automatic logic [8:0] half_limit(input logic [1:0] pp, input logic [2:0] sp);
		logic [6:0] pri;
		logic [3:0] sec;
		case (pp)
			2'b11:   pri = PRI_1;
			2'b10:   pri = PRI_4;
			2'b01:   pri = PRI_16;
			default: pri = PRI_64;
		endcase
		sec = SEC_BASE - {1'b0, sp};
		half_limit = 9'(11'(pri) * 11'(sec) - LIM_ONE);
	endfunction

endpackage

// File: core/spi_master_slave_port.sv
// Function
// R1 - 16-bit shift register; each transfer clocks 8 or 16 bits out and in.
// R2 - every finished transfer sets the done flag; an enable bit masks it.
// R3 - a finished word is copied from shift register into receive buffer.
// R4 - unread receive buffer at completion: set overflow, drop the new word.
// R5 - while overflow stands with buffer unread, shift clock edges are ignored.
// R6 - transfer end moves data to receive side, then pending transmit word loads.
// R7 - buffer address: writes fill transmit side, reads return receive side.
// R8 - master makes the shift clock from prescaler; writing buffer starts it.
// R9 - master raises done at the mid-bit capture of the last bit.
// R10 - slave shifts on external clock; done when the last bit is latched.
// R11 - select high in select mode stops output drive and transfers.
// R12 - shift clock is system clock through primary and secondary prescalers.
// R13 - one bit sets idle clock level, another sets the launching edge.
// R14 - word size bit picks 16 or 8 bit transfers, otherwise identical.
// R15 - changing the word size bit resets the port.
// R16 - output from bit 7 or bit 15; input enters at bit 0.
// R17 - output disable bit releases the serial output pin.
// R18 - framed mode uses select pin as frame sync; direction bit picks source.
// R19 - frame pulse high for one clock cycle; data follows on next edges.
// R20 - slave select rising resets counters; next transfer starts at the MSB.
// R21 - sleep aborts any transfer; register contents stay unchanged.
// R22 - stop-in-idle bit 13 halts the port during idle when set.
// R23 - module enable clear: pins ignored, shift logic held idle.
// R24 - master enable set drives the shift clock; clear receives it.
`timescale 1ns/10ps
`default_nettype none

module spi_master_slave_port (
	input  wire logic                              sys_clk,
	input  wire logic                              reset_n,
	input  wire logic [spi_port_pkg::AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [31:0]                       s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [spi_port_pkg::AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [31:0]                            s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	input  wire logic                              serial_in_pin,
	output logic                                   serial_out_pin,
	output logic                                   serial_out_oe,
	input  wire logic                              shift_clock_in,
	output logic                                   shift_clock_out,
	output logic                                   shift_clock_oe,
	input  wire logic                              slave_select_n_in,
	output logic                                   slave_select_n_out,
	output logic                                   slave_select_oe,
	input  wire logic                              sleep_req,
	input  wire logic                              idle_req,
	output logic                                   transfer_done_irq
);
	import spi_port_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic          en_r, en_nxt, sidl_r, sidl_nxt, ovf_r, ovf_nxt;
	logic          tbf_r, tbf_nxt, rbf_r, rbf_nxt, ifl_r, ifl_nxt, ie_r, ie_nxt;
	logic [15:0]   con_r, con_nxt, tx_r, tx_nxt, rx_r, rx_nxt, sr_r, sr_nxt;
	logic [4:0]    cnt_r, cnt_nxt;
	logic [8:0]    div_r, div_nxt;
	logic          sdo_r, sdo_nxt, sck_r, sck_nxt, ssout_r, ssout_nxt;
	logic          fcnt_r, fcnt_nxt, mdone_r, mdone_nxt, armed_r, armed_nxt;
	master_state_e st_r, st_nxt;
	logic          aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [9:0]    aw_idx_r, aw_idx_nxt;
	logic [15:0]   wd_r, wd_nxt, wm_r, wm_nxt;
	logic          bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]    bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0]   rdata_r, rdata_nxt;
	logic          sck_s1, sck_s2, sck_p, sdi_s1, sdi_s2, ss_s1, ss_s2;

	// ----------------------------------------
	// decoded control
	// ----------------------------------------
	logic        master, clock_polarity_select, cke, select_control_enable, framed_mode_enable, fsd, m16, run, abort, stall;
	logic        tick, edge_hit, lead, capture, launch, go, done, wr_fire;
	logic        wr_buf, m16_chg;
	logic [4:0]  nbits;
	logic [8:0]  lim;
	logic [15:0] stat_w, merged, sr_sh, rd_val;
	logic [9:0]  ar_idx;

	assign s_axi_awready      = !aw_hold_r && !bvalid_r;
	assign s_axi_wready       = !w_hold_r && !bvalid_r;
	assign s_axi_arready      = !rvalid_r;
	assign s_axi_bvalid       = bvalid_r;
	assign s_axi_bresp        = bresp_r;
	assign s_axi_rvalid       = rvalid_r;
	assign s_axi_rresp        = rresp_r;
	assign s_axi_rdata        = rdata_r;
	assign serial_out_pin     = sdo_r;
	assign shift_clock_out    = sck_r;
	assign slave_select_n_out = ssout_r;
	assign transfer_done_irq  = ifl_r && ie_r;

	// R17 output disable
	// R11 select releases output
	assign serial_out_oe   = en_r && !con_r[CN_DIS]
		&& (con_r[CN_MST] || !con_r[CN_SELECT_CONTROL_ENABLE] || con_r[CN_FRM] || !ss_s2);
	// R24 master drives clock
	assign shift_clock_oe  = en_r && con_r[CN_MST];
	// R18 frame sync direction
	assign slave_select_oe = en_r && con_r[CN_MST] && con_r[CN_FRM] && !con_r[CN_FSD];

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_p  <= 1'b0;
			sdi_s1 <= 1'b0;
			sdi_s2 <= 1'b0;
			ss_s1  <= 1'b1;
			ss_s2  <= 1'b1;
		end
		else
		begin
			sck_s1 <= shift_clock_in;
			sck_s2 <= sck_s1;
			sck_p  <= sck_s2;
			sdi_s1 <= serial_in_pin;
			sdi_s2 <= sdi_s1;
			ss_s1  <= slave_select_n_in;
			ss_s2  <= ss_s1;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		{en_nxt, sidl_nxt, ovf_nxt, tbf_nxt, rbf_nxt} = {en_r, sidl_r, ovf_r, tbf_r, rbf_r};
		{ifl_nxt, ie_nxt, con_nxt, tx_nxt, rx_nxt} = {ifl_r, ie_r, con_r, tx_r, rx_r};
		{sr_nxt, cnt_nxt, div_nxt, sdo_nxt, sck_nxt} = {sr_r, cnt_r, div_r, sdo_r, sck_r};
		{ssout_nxt, fcnt_nxt, mdone_nxt, armed_nxt, st_nxt} =
			{ssout_r, fcnt_r, mdone_r, armed_r, st_r};
		{aw_hold_nxt, w_hold_nxt, aw_idx_nxt, wd_nxt, wm_nxt} =
			{aw_hold_r, w_hold_r, aw_idx_r, wd_r, wm_r};
		{bvalid_nxt, bresp_nxt, rvalid_nxt, rresp_nxt, rdata_nxt} =
			{bvalid_r, bresp_r, rvalid_r, rresp_r, rdata_r};

		master = con_r[CN_MST];
		clock_polarity_select    = con_r[CN_CKP];
		cke    = con_r[CN_CKE];
		select_control_enable   = con_r[CN_SELECT_CONTROL_ENABLE];
		framed_mode_enable  = con_r[CN_FRM];
		fsd    = con_r[CN_FSD];
		m16    = con_r[CN_M16];
		// R14 word size
		nbits  = m16 ? BITS16 : BITS8;
		// R12 prescaler chain
		lim    = half_limit(con_r[CN_PPRE+:2], con_r[CN_SPRE+:3]);
		// R21 sleep aborts
		// R23 disabled port idle
		abort  = !en_r || sleep_req;
		// R22 stop in idle
		run    = !abort && !(idle_req && sidl_r);
		// R5 overflow stall
		stall  = ovf_r && rbf_r;

		stat_w = 16'h0000;
		stat_w[ST_EN]   = en_r;
		stat_w[ST_SIDL] = sidl_r;
		stat_w[ST_OVF]  = ovf_r;
		stat_w[ST_TBF]  = tbf_r;
		stat_w[ST_RBF]  = rbf_r;

		// ----------------------------------------
		// register bus: write side
		// ----------------------------------------
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_nxt = 1'b1;
			aw_idx_nxt  = s_axi_awaddr[AXI_AW-1:2];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_nxt = 1'b1;
			wd_nxt     = s_axi_wdata[15:0];
			wm_nxt     = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
		end
		wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
		wr_buf  = 1'b0;
		m16_chg = 1'b0;
		merged  = 16'h0000;
		if (wr_fire)
		begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = RESP_OKAY;
			case (aw_idx_r)
				IDX_STAT:
				begin
					merged   = (stat_w & ~wm_r) | (wd_r & wm_r);
					en_nxt   = merged[ST_EN];
					sidl_nxt = merged[ST_SIDL];
					ovf_nxt  = ovf_r && merged[ST_OVF];
				end
				IDX_CON:
				begin
					merged  = ((con_r & ~wm_r) | (wd_r & wm_r)) & CON_MASK;
					con_nxt = merged;
					m16_chg = merged[CN_M16] != m16;
				end
				// R7 write goes to transmit side
				IDX_BUF:
				begin
					tx_nxt  = (tx_r & ~wm_r) | (wd_r & wm_r);
					tbf_nxt = 1'b1;
					wr_buf  = 1'b1;
				end
				IDX_IRQ:
				begin
					if (wm_r[IQ_FLAG] && wd_r[IQ_FLAG])
						ifl_nxt = 1'b0;
					if (wm_r[IQ_EN])
						ie_nxt = wd_r[IQ_EN];
				end
				default:
					bresp_nxt = RESP_SLV;
			endcase
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;

		// ----------------------------------------
		// register bus: read side
		// ----------------------------------------
		ar_idx = s_axi_araddr[AXI_AW-1:2];
		rd_val = 16'h0000;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = RESP_OKAY;
			case (ar_idx)
				IDX_STAT: rd_val = stat_w;
				IDX_CON:  rd_val = con_r;
				// R7 read returns receive side
				IDX_BUF:
				begin
					rd_val  = rx_r;
					rbf_nxt = 1'b0;
				end
				IDX_IRQ:
				begin
					rd_val[IQ_FLAG] = ifl_r;
					rd_val[IQ_EN]   = ie_r;
				end
				default:  rresp_nxt = RESP_SLV;
			endcase
			rdata_nxt = {16'h0000, rd_val};
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;

		// ----------------------------------------
		// shift clock edges
		// ----------------------------------------
		tick     = run && master && st_r != ST_IDLE && div_r == lim;
		if (run && master && st_r != ST_IDLE)
			div_nxt = tick ? DIV_ZERO : div_r + DIV_ONE;
		else if (!run && !abort)
			div_nxt = div_r;
		else
			div_nxt = DIV_ZERO;
		// R10 slave uses external clock
		edge_hit = master ? (tick && st_r == ST_SHIFT && !mdone_r)
			: (run && sck_s2 != sck_p);
		lead     = master ? (sck_r == clock_polarity_select) : (sck_s2 != clock_polarity_select);
		// R13 launch and capture edges
		capture  = edge_hit && (lead == cke);
		launch   = edge_hit && (lead != cke);
		// R19 framed data after pulse
		// R11 select gates the slave
		go = !stall && (master || (framed_mode_enable ? (armed_r && ss_s2 == 1'b0)
			: (!select_control_enable || !ss_s2)));

		// R18 slave arms on frame pulse
		if (run && !master && framed_mode_enable && cnt_r == 5'h00 && sck_s2 != sck_p && ss_s2)
			armed_nxt = 1'b1;

		if (tick)
			sck_nxt = ~sck_r;

		// ----------------------------------------
		// master sequencer
		// ----------------------------------------
		case (st_r)
			ST_IDLE:
			begin
				sck_nxt   = clock_polarity_select;
				ssout_nxt = 1'b0;
				// R8 buffer write starts master
				if (run && master && tbf_r && !stall && !wr_buf
					&& (!(framed_mode_enable && fsd) || ss_s2))
				begin
					sr_nxt    = tx_r;
					tbf_nxt   = 1'b0;
					sdo_nxt   = m16 ? tx_r[MSB16] : tx_r[MSB8];
					fcnt_nxt  = 1'b0;
					mdone_nxt = 1'b0;
					st_nxt    = (framed_mode_enable && !fsd) ? ST_FRAME : ST_SHIFT;
					ssout_nxt = framed_mode_enable && !fsd;
				end
			end
			// R19 one clock cycle pulse
			ST_FRAME:
			begin
				if (tick)
				begin
					fcnt_nxt = ~fcnt_r;
					if (fcnt_r)
					begin
						ssout_nxt = 1'b0;
						st_nxt    = ST_SHIFT;
					end
				end
			end
			ST_SHIFT:
			begin
				if (mdone_r && sck_r == clock_polarity_select)
				begin
					mdone_nxt = 1'b0;
					st_nxt    = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase

		// ----------------------------------------
		// shift engine
		// ----------------------------------------
		// R6 slave loads pending word
		if (run && !master && cnt_r == 5'h00 && !capture)
		begin
			if (tbf_r && !wr_buf)
			begin
				sr_nxt  = tx_r;
				tbf_nxt = 1'b0;
				sdo_nxt = m16 ? tx_r[MSB16] : tx_r[MSB8];
			end
			else
				sdo_nxt = m16 ? sr_r[MSB16] : sr_r[MSB8];
		end
		// R16 msb out, lsb in
		if (launch && go && cnt_r != 5'h00)
			sdo_nxt = m16 ? sr_r[MSB16] : sr_r[MSB8];
		sr_sh = {sr_r[14:0], sdi_s2};
		done  = 1'b0;
		// R1 shift one bit
		if (capture && go)
		begin
			sr_nxt  = sr_sh;
			cnt_nxt = cnt_r + CNT_ONE;
			done    = cnt_nxt == nbits;
		end
		if (done)
		begin
			cnt_nxt   = 5'h00;
			armed_nxt = 1'b0;
			mdone_nxt = master;
			// R9 done at last capture
			// R2 set done flag
			ifl_nxt   = 1'b1;
			// R4 overflow drops word
			if (rbf_r)
				ovf_nxt = 1'b1;
			else
			begin
				// R3 copy to receive buffer
				rx_nxt  = sr_sh;
				rbf_nxt = 1'b1;
			end
		end

		// R20 select high resynchronises
		if (run && !master && select_control_enable && !framed_mode_enable && ss_s2)
		begin
			cnt_nxt = 5'h00;
			sdo_nxt = m16 ? sr_nxt[MSB16] : sr_nxt[MSB8];
		end

		// R21 abort keeps registers
		if (abort)
		begin
			cnt_nxt   = 5'h00;
			st_nxt    = ST_IDLE;
			sck_nxt   = clock_polarity_select;
			ssout_nxt = 1'b0;
			mdone_nxt = 1'b0;
			armed_nxt = 1'b0;
		end

		// R15 word size change resets port
		if (m16_chg)
		begin
			cnt_nxt   = 5'h00;
			st_nxt    = ST_IDLE;
			ssout_nxt = 1'b0;
			mdone_nxt = 1'b0;
			armed_nxt = 1'b0;
			tbf_nxt   = 1'b0;
			rbf_nxt   = 1'b0;
			ovf_nxt   = 1'b0;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			en_r      <= RST_STAT[ST_EN];
			sidl_r    <= RST_STAT[ST_SIDL];
			ovf_r     <= RST_STAT[ST_OVF];
			tbf_r     <= RST_STAT[ST_TBF];
			rbf_r     <= RST_STAT[ST_RBF];
			ifl_r     <= 1'b0;
			ie_r      <= 1'b0;
			con_r     <= RST_CON;
			tx_r      <= RST_BUF;
			rx_r      <= RST_BUF;
			sr_r      <= RST_BUF;
			cnt_r     <= 5'h00;
			div_r     <= DIV_ZERO;
			sdo_r     <= 1'b0;
			sck_r     <= RST_CON[CN_CKP];
			ssout_r   <= 1'b0;
			fcnt_r    <= 1'b0;
			mdone_r   <= 1'b0;
			armed_r   <= 1'b0;
			st_r      <= ST_IDLE;
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			aw_idx_r  <= 10'h000;
			wd_r      <= 16'h0000;
			wm_r      <= 16'h0000;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			rvalid_r  <= 1'b0;
			rresp_r   <= RESP_OKAY;
			rdata_r   <= 32'h0000_0000;
		end
		else
		begin
			en_r      <= en_nxt;
			sidl_r    <= sidl_nxt;
			ovf_r     <= ovf_nxt;
			tbf_r     <= tbf_nxt;
			rbf_r     <= rbf_nxt;
			ifl_r     <= ifl_nxt;
			ie_r      <= ie_nxt;
			con_r     <= con_nxt;
			tx_r      <= tx_nxt;
			rx_r      <= rx_nxt;
			sr_r      <= sr_nxt;
			cnt_r     <= cnt_nxt;
			div_r     <= div_nxt;
			sdo_r     <= sdo_nxt;
			sck_r     <= sck_nxt;
			ssout_r   <= ssout_nxt;
			fcnt_r    <= fcnt_nxt;
			mdone_r   <= mdone_nxt;
			armed_r   <= armed_nxt;
			st_r      <= st_nxt;
			aw_hold_r <= aw_hold_nxt;
			w_hold_r  <= w_hold_nxt;
			aw_idx_r  <= aw_idx_nxt;
			wd_r      <= wd_nxt;
			wm_r      <= wm_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

endmodule

`default_nettype wire

// File: testbench/spi_port_chk.sv
`timescale 1ns/10ps
`default_nettype none

module spi_port_chk (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        serial_out_oe,
	input wire logic        shift_clock_oe,
	input wire logic        slave_select_oe,
	input wire logic        transfer_done_irq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	chk_wr_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response not on time");
	chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read response not on time");
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped early");
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	chk_irq_holds: assert property (transfer_done_irq && !s_axi_bvalid |=> transfer_done_irq || s_axi_bvalid)
		else $error("interrupt dropped without a register write");
	chk_frame_master: assert property (slave_select_oe |-> shift_clock_oe)
		else $error("frame pulse driven outside master mode");
	chk_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !shift_clock_oe && !serial_out_oe)
		else $error("pins driven after reset");
endmodule

bind spi_master_slave_port spi_port_chk chk_i (
	.sys_clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .serial_out_oe, .shift_clock_oe,
	.slave_select_oe, .transfer_done_irq
);

`default_nettype wire

// File: testbench/spi_peer_model.sv
`timescale 1ns/10ps
`default_nettype none

module spi_peer_model (
	input  wire logic        sck,
	input  wire logic        mosi,
	input  wire logic        frame_sync_pulse,
	input  wire logic        load,
	input  wire logic [15:0] load_word,
	output logic             miso,
	output logic [15:0]      rx_word
);
	logic [15:0] tx_r;
	logic        fs_seen = 1'b0;
	logic        fs_done = 1'b0;

	assign miso = tx_r[15];

	// the clock cycle under the frame pulse carries no data
	always @(posedge sck)
		if (frame_sync_pulse)
			fs_seen <= ~fs_seen;
		else
			rx_word <= {rx_word[14:0], mosi};

	// next bit on return to idle
	always @(negedge sck or posedge load)
		if (load)
			tx_r <= load_word;
		else if (fs_done != fs_seen)
			fs_done <= fs_seen;
		else
			tx_r <= {tx_r[14:0], 1'b0};
endmodule

`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import spi_port_pkg::*;

	logic        sys_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, serial_out_pin, serial_out_oe, shift_clock_out, shift_clock_oe;
	logic        slave_select_n_out, slave_select_oe, sleep_req, idle_req, transfer_done_irq;
	logic        miso, load;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rd_rsp;
	logic [15:0] load_word, peer_rx;
	int          err_total, comparisons;
	wire logic   mosi_w, sck_w, ss_w;

	// pin levels: data line pulled up, clock idles low, select idles high
	assign mosi_w = serial_out_oe ? serial_out_pin : 1'b1;
	assign sck_w  = shift_clock_oe ? shift_clock_out : 1'b0;
	assign ss_w   = slave_select_oe ? slave_select_n_out : 1'b1;

	spi_master_slave_port DUT (
		.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_in_pin(miso), .serial_out_pin,
		.serial_out_oe, .shift_clock_in(sck_w), .shift_clock_out, .shift_clock_oe,
		.slave_select_n_in(ss_w), .slave_select_n_out, .slave_select_oe, .sleep_req,
		.idle_req, .transfer_done_irq
	);

	spi_peer_model peer (.sck(sck_w), .mosi(mosi_w),
		.frame_sync_pulse(slave_select_oe && slave_select_n_out),
		.load, .load_word, .miso, .rx_word(peer_rx));

	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d, err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
		logic aw_ok, w_ok, b_ok;
		b_ok = 1'b0;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		for (int i = 0; i < 100 && !b_ok; i++)
		begin
			@(negedge sys_clk);
			aw_ok = s_axi_awvalid && s_axi_awready;
			w_ok  = s_axi_wvalid && s_axi_wready;
			b_ok  = s_axi_bvalid;
			rd_rsp = s_axi_bresp;
			@(posedge sys_clk);
			if (aw_ok)
				s_axi_awvalid <= 1'b0;
			if (w_ok)
				s_axi_wvalid <= 1'b0;
		end
		cmp({30'h0, rd_rsp}, {30'h0, er});
	endtask

	task automatic rd_raw(input logic [11:0] a);
		logic ar_ok, r_ok;
		r_ok = 1'b0;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		for (int i = 0; i < 100 && !r_ok; i++)
		begin
			@(negedge sys_clk);
			ar_ok  = s_axi_arvalid && s_axi_arready;
			r_ok   = s_axi_rvalid;
			rd_val = s_axi_rdata;
			rd_rsp = s_axi_rresp;
			@(posedge sys_clk);
			if (ar_ok)
				s_axi_arvalid <= 1'b0;
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
		rd_raw(a);
		cmp(rd_val, {16'h0000, e});
		cmp({30'h0, rd_rsp}, {30'h0, er});
	endtask

	task automatic poll(input logic [11:0] a, input int b);
		rd_val = 32'h0000_0000;
		for (int i = 0; i < 60 && !rd_val[b]; i++)
			rd_raw(a);
		cmp({31'h0, rd_val[b]}, 32'h0000_0001);
	endtask

	task automatic xfer(input logic [15:0] pw, input logic [15:0] dw);
		load_word <= pw;
		load      <= 1'b1;
		@(posedge sys_clk);
		load <= 1'b0;
		wr(12'h890, dw, RESP_OKAY);
	endtask

	task automatic wait_irq;
		for (int i = 0; i < 300 && !transfer_done_irq; i++)
			@(posedge sys_clk);
		cmp({31'h0, transfer_done_irq}, 32'h0000_0001);
	endtask

	initial
	begin
		#100000;
		err_total++;
		print_verdict;
	end

	initial
	begin
		{reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		// response channels are always ready to take an answer
		{s_axi_bready, s_axi_rready} = 2'b11;
		{sleep_req, idle_req, load} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, load_word} = '0;
		s_axi_wstrb = 4'hf;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		rd(12'h880, RST_STAT, RESP_OKAY);
		rd(12'h888, RST_CON, RESP_OKAY);
		rd(12'h890, RST_BUF, RESP_OKAY);
		rd(12'h8a0, 16'h0000, RESP_SLV);
		wr(12'h8a0, 16'hffff, RESP_SLV);
		rd(12'h888, 16'h0000, RESP_OKAY);
		// half period of four clocks leaves room for the input synchroniser
		wr(12'h888, 16'h013e, RESP_OKAY);
		rd(12'h888, 16'h013e, RESP_OKAY);
		wr(12'h898, 16'h0002, RESP_OKAY);
		wr(12'h880, 16'h8000, RESP_OKAY);
		cmp({31'h0, shift_clock_oe}, 32'h0000_0001);
		xfer(16'h3c00, 16'h00a5);
		wait_irq;
		cmp({24'h0, peer_rx[7:0]}, 32'h0000_00a5);
		rd(12'h880, 16'h8001, RESP_OKAY);
		rd_raw(12'h890);
		cmp({24'h0, rd_val[7:0]}, 32'h0000_003c);
		rd(12'h880, 16'h8000, RESP_OKAY);
		wr(12'h898, 16'h0001, RESP_OKAY);
		cmp({31'h0, transfer_done_irq}, 32'h0000_0000);
		xfer(16'h5a00, 16'h00c3);
		poll(12'h898, IQ_FLAG);
		cmp({31'h0, transfer_done_irq}, 32'h0000_0000);
		cmp({24'h0, peer_rx[7:0]}, 32'h0000_00c3);
		xfer(16'h6600, 16'h0081);
		poll(12'h880, ST_OVF);
		rd(12'h880, 16'h8041, RESP_OKAY);
		rd_raw(12'h890);
		cmp({24'h0, rd_val[7:0]}, 32'h0000_005a);
		rd(12'h880, 16'h8040, RESP_OKAY);
		wr(12'h880, 16'h0000, RESP_OKAY);
		wr(12'h888, 16'h453e, RESP_OKAY);
		wr(12'h880, 16'h8000, RESP_OKAY);
		wr(12'h898, 16'h0003, RESP_OKAY);
		xfer(16'h1234, 16'hbeef);
		wait_irq;
		cmp({16'h0, peer_rx}, 32'h0000_beef);
		rd(12'h890, 16'h1234, RESP_OKAY);
		wr(12'h898, 16'h0003, RESP_OKAY);
		sleep_req <= 1'b1;
		xfer(16'h0000, 16'h0055);
		repeat (200) @(posedge sys_clk);
		cmp({31'h0, transfer_done_irq}, 32'h0000_0000);
		rd(12'h880, 16'h8002, RESP_OKAY);
		sleep_req <= 1'b0;
		wait_irq;
		cmp({16'h0, peer_rx}, 32'h0000_0055);
		cmp({31'h0, serial_out_oe}, 32'h0000_0001);
		wr(12'h888, 16'h4d3e, RESP_OKAY);
		cmp({31'h0, serial_out_oe}, 32'h0000_0000);
		print_verdict;
	end
endmodule

`default_nettype wire
